// ===== inc/vad_map.svh
// Offsets, codes and timing constants of the videotex autodialer
`ifndef VAD_MAP_SVH
`define VAD_MAP_SVH
// Clock and time units
`define VAD_CLK_PERIOD_NS      5
`define VAD_MS_TIME_NS         1000000
`define VAD_NVM_CLK_HZ         14000
// Timeouts and dial pulse timing, in milliseconds
`define VAD_LOOP_TIMEOUT_MS    16'd30000
`define VAD_CARRIER_TIMEOUT_MS 16'd30000
`define VAD_PAUSE_TIMEOUT_MS   16'd4000
`define VAD_BREAK_MS           16'd66
`define VAD_MAKE_MS            16'd34
`define VAD_INTERDIGIT_MS      16'd700
// Binary keypad codes
`define VAD_KEY_SQUARE         7'h72
`define VAD_KEY_HOLD           7'h6B
`define VAD_KEY_PICTEXT        7'h60
`define VAD_KEY_DIG1           7'h6C
`define VAD_KEY_DIG2           7'h6D
`define VAD_KEY_DIG3           7'h6E
`define VAD_KEY_DIG4           7'h68
// ASCII keypad codes
`define VAD_ASC_SQUARE         7'h23
`define VAD_ASC_DIG1           7'h31
`define VAD_ASC_DIG4           7'h34
// Store layout: block index 0 is block 1
`define VAD_BLK_IDENTITY       3'h0
`define VAD_BLK_NUM_A          3'h1
`define VAD_BLK_NUM_B          3'h2
`define VAD_BLK_NUM_E          3'h5
`define VAD_BLK_NUM_F          3'h6
`define VAD_BLK_CHARS          5'h10
// Stored character low nibbles
`define VAD_CODE_DIGIT_MAX     4'h9
`define VAD_CODE_PAUSE         4'hB
`define VAD_CODE_FILL          4'hF
// Display characters
`define VAD_DISP_ZERO          7'h30
`define VAD_DISP_SPACE         7'h20
`define VAD_DISP_STAR          7'h2A
// Serial memory modes, bit 2 is the shared carrier pin
`define VAD_NVM_MODE_STANDBY   3'h0
`define VAD_NVM_MODE_ADDR      3'h3
`define VAD_NVM_MODE_READ      3'h1
`define VAD_NVM_MODE_SHIFT     3'h5
`define VAD_NVM_ADDR_BITS      4'h8
`define VAD_NVM_DATA_BITS      4'h8
`endif

// ===== inc/vad_pkg.sv
// Types shared by the autodialer modules
package vad_pkg;
  typedef enum logic [3:0] {
    ST_IDLE    = 4'h0,
    ST_LOOPED  = 4'h1,
    ST_FETCH   = 4'h3,
    ST_BREAK   = 4'h2,
    ST_MAKE    = 4'h6,
    ST_GAP     = 4'h7,
    ST_NEXT    = 4'h5,
    ST_PAUSE   = 4'h4,
    ST_WAITCAR = 4'hC,
    ST_ONLINE  = 4'hD,
    ST_IDSEND  = 4'hF
  } vad_state_t;
  typedef enum logic [2:0] {
    NV_IDLE  = 3'h0,
    NV_ADDR  = 3'h1,
    NV_READ  = 3'h3,
    NV_SHIFT = 3'h2,
    NV_DONE  = 3'h6
  } vad_nvm_state_t;
endpackage : vad_pkg

// ===== verilog/vad_nvm_port.sv
// Serial non-volatile store port: address out, one character back
`timescale 1ns/1ps
`include "vad_map.svh"
module vad_nvm_port #(
  parameter int HALF_DIV = 7142
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  input  wire logic       start,
  input  wire logic [7:0] addr,
  input  wire logic       data_in,
  output logic            done_ff,
  output logic [7:0]      rdata_ff,
  output logic            idle_ff,
  output logic            nclk_ff,
  output logic [2:0]      mode_ff,
  output logic            mode_c_oe_n_ff,
  output logic            data_o_ff,
  output logic            data_oe_n_ff
);
  vad_pkg::vad_nvm_state_t st_ff, nxt_st;
  logic [12:0] div_ff, nxt_div;
  logic [3:0]  bit_ff, nxt_bit;
  logic [7:0]  sh_ff, nxt_sh;
  logic [7:0]  nxt_rdata;
  logic        nxt_nclk, nxt_done, nxt_data_o, nxt_data_oe_n, nxt_c_oe_n;
  logic [2:0]  nxt_mode;
  logic        rise;

  always_comb
  begin
    nxt_st        = st_ff;
    nxt_div       = div_ff;
    nxt_bit       = bit_ff;
    nxt_sh        = sh_ff;
    nxt_rdata     = rdata_ff;
    nxt_nclk      = nclk_ff;
    nxt_done      = 1'b0;
    nxt_data_o    = data_o_ff;
    nxt_data_oe_n = data_oe_n_ff;
    nxt_mode      = mode_ff;
    nxt_c_oe_n    = mode_c_oe_n_ff;
    rise          = 1'b0;
    // Memory clock runs only while a transfer is busy
    if (st_ff != vad_pkg::NV_IDLE && st_ff != vad_pkg::NV_DONE)
    begin
      if (div_ff == 13'(HALF_DIV - 1))
      begin
        nxt_div  = 13'h0;
        nxt_nclk = ~nclk_ff;
        rise     = ~nclk_ff;
      end
      else
        nxt_div = div_ff + 13'h1;
    end
    case (st_ff)
      vad_pkg::NV_IDLE:
        if (start)
        begin
          nxt_st        = vad_pkg::NV_ADDR;
          nxt_sh        = addr;
          nxt_bit       = 4'h0;
          nxt_div       = 13'h0;
          nxt_mode      = `VAD_NVM_MODE_ADDR;
          nxt_c_oe_n    = 1'b0;
          nxt_data_oe_n = 1'b0;
          nxt_data_o    = addr[7];
        end
      vad_pkg::NV_ADDR:
        if (rise)
        begin
          nxt_sh     = {sh_ff[6:0], 1'b0};
          nxt_data_o = sh_ff[6];
          nxt_bit    = bit_ff + 4'h1;
          if (bit_ff == `VAD_NVM_ADDR_BITS - 4'h1)
          begin
            nxt_st        = vad_pkg::NV_READ;
            nxt_mode      = `VAD_NVM_MODE_READ;
            nxt_data_oe_n = 1'b1;
          end
        end
      vad_pkg::NV_READ:
        if (rise)
        begin
          nxt_st   = vad_pkg::NV_SHIFT;
          nxt_bit  = 4'h0;
          nxt_mode = `VAD_NVM_MODE_SHIFT;
        end
      vad_pkg::NV_SHIFT:
        if (rise)
        begin
          nxt_sh  = {sh_ff[6:0], data_in};
          nxt_bit = bit_ff + 4'h1;
          if (bit_ff == `VAD_NVM_DATA_BITS - 4'h1)
          begin
            nxt_st     = vad_pkg::NV_DONE;
            nxt_rdata  = {sh_ff[6:0], data_in};
            nxt_mode   = `VAD_NVM_MODE_STANDBY;
            nxt_c_oe_n = 1'b1;
            nxt_nclk   = 1'b0;
          end
        end
      vad_pkg::NV_DONE:
      begin
        nxt_done = 1'b1;
        nxt_st   = vad_pkg::NV_IDLE;
      end
      default:
        nxt_st = vad_pkg::NV_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_ff          <= vad_pkg::NV_IDLE;
      div_ff         <= 13'h0;
      bit_ff         <= 4'h0;
      sh_ff          <= 8'h0;
      rdata_ff       <= 8'h0;
      nclk_ff        <= 1'b0;
      done_ff        <= 1'b0;
      idle_ff        <= 1'b1;
      data_o_ff      <= 1'b0;
      data_oe_n_ff   <= 1'b1;
      mode_ff        <= `VAD_NVM_MODE_STANDBY;
      mode_c_oe_n_ff <= 1'b1;
    end
    else if (ce)
    begin
      st_ff          <= nxt_st;
      div_ff         <= nxt_div;
      bit_ff         <= nxt_bit;
      sh_ff          <= nxt_sh;
      rdata_ff       <= nxt_rdata;
      nclk_ff        <= nxt_nclk;
      done_ff        <= nxt_done;
      idle_ff        <= (nxt_st == vad_pkg::NV_IDLE);
      data_o_ff      <= nxt_data_o;
      data_oe_n_ff   <= nxt_data_oe_n;
      mode_ff        <= nxt_mode;
      mode_c_oe_n_ff <= nxt_c_oe_n;
    end
  end
endmodule : vad_nvm_port

// ===== verilog/vad_dialer.sv
// Autodialer and terminal identity sequencer for a videotex terminal
`timescale 1ns/1ps
`include "vad_map.svh"
module vad_dialer #(
  parameter int MS_CYCLES = `VAD_MS_TIME_NS / `VAD_CLK_PERIOD_NS,
  parameter int NVM_HALF  = 1000000000 / (2 * `VAD_NVM_CLK_HZ * `VAD_CLK_PERIOD_NS)
) (
  input  wire logic       CLOCK,
  input  wire logic       RSTN,
  input  wire logic       CLK_EN,
  input  wire logic       KEY_VALID,
  input  wire logic [6:0] KEY_CODE,
  input  wire logic       DISP_VIDEOTEX,
  input  wire logic       ID_REQ,
  output logic            LINE_RELAY,
  output logic            MASK_RELAY,
  output logic            DIAL_RELAY,
  output logic            SET_TEXT_MODE,
  output logic            CLEAR_STORE,
  output logic            CHAR_VALID,
  output logic [6:0]      CHAR_CODE,
  output logic            ID_VALID,
  output logic [3:0]      ID_DIGIT,
  output logic            CARRIER_UP,
  output logic            NVM_CLK,
  output logic            MEM_MODE_CTL_A,
  output logic            MEM_MODE_CTL_B,
  output logic            MEM_MODE_CTL_C_O,
  output logic            MEM_MODE_CTL_C_OE_N,
  input  wire logic       MEM_MODE_CTL_C_I,
  output logic            NVM_DATA_O,
  output logic            NVM_DATA_OE_N,
  input  wire logic       NVM_DATA_I
);
  vad_pkg::vad_state_t st_ff, nxt_st;
  logic [17:0] pre_ff, nxt_pre;
  logic        tick_ff, nxt_tick;
  logic [15:0] tmr_ff, nxt_tmr;
  logic [2:0]  blk_ff, nxt_blk;
  logic [4:0]  chr_ff, nxt_chr;
  logic [3:0]  pls_ff, nxt_pls;
  logic [6:0]  sel_ff, nxt_sel;
  logic        vtx_ff;
  logic        start_ff, nxt_start;
  logic        nxt_text, nxt_clear, nxt_cvalid, nxt_ivalid;
  logic [6:0]  nxt_ccode;
  logic [3:0]  nxt_idig;
  logic [2:0]  car_sync_ff, dat_sync_ff;
  logic        carrier_ff, nxt_carrier;
  logic        done;
  logic        nvm_idle;
  logic [7:0]  rdata;
  logic [2:0]  mode;
  logic [3:0]  nib;
  logic        is_square, is_release, is_dig;
  logic [2:0]  dig_blk;

  // Mode pin C doubles as carrier sense; only trusted while released
  vad_nvm_port #(
    .HALF_DIV (NVM_HALF)
  ) u_nvm (
    .clk            (CLOCK),
    .rst_n          (RSTN),
    .ce             (CLK_EN),
    .start          (start_ff),
    .addr           ({1'b0, blk_ff, chr_ff[3:0]}),
    .data_in        (dat_sync_ff[2]),
    .done_ff        (done),
    .rdata_ff       (rdata),
    .idle_ff        (nvm_idle),
    .nclk_ff        (NVM_CLK),
    .mode_ff        (mode),
    .mode_c_oe_n_ff (MEM_MODE_CTL_C_OE_N),
    .data_o_ff      (NVM_DATA_O),
    .data_oe_n_ff   (NVM_DATA_OE_N)
  );

  assign MEM_MODE_CTL_A   = mode[0];
  assign MEM_MODE_CTL_B   = mode[1];
  assign MEM_MODE_CTL_C_O = mode[2];
  assign CARRIER_UP       = carrier_ff;
  assign nib              = rdata[3:0];

  // Key decode accepts both binary pad codes and ASCII for square and digits; release keys are binary pad codes only
  always_comb
  begin
    is_square  = KEY_VALID && (KEY_CODE == `VAD_KEY_SQUARE || KEY_CODE == `VAD_ASC_SQUARE);
    is_release = KEY_VALID && (KEY_CODE == `VAD_KEY_HOLD || KEY_CODE == `VAD_KEY_PICTEXT);
    is_dig     = KEY_VALID;
    dig_blk    = `VAD_BLK_NUM_A;
    case (KEY_CODE)
      `VAD_KEY_DIG1, `VAD_ASC_DIG1:       dig_blk = `VAD_BLK_NUM_A;
      `VAD_KEY_DIG2, `VAD_ASC_DIG1 + 7'h1: dig_blk = `VAD_BLK_NUM_B;
      `VAD_KEY_DIG3, `VAD_ASC_DIG4 - 7'h1: dig_blk = `VAD_BLK_NUM_E;
      `VAD_KEY_DIG4, `VAD_ASC_DIG4:       dig_blk = `VAD_BLK_NUM_F;
      default:                            is_dig  = 1'b0;
    endcase
  end

  // Carrier level changes only when the last two sync stages agree
  always_comb
  begin
    nxt_carrier = carrier_ff;
    if (nvm_idle && MEM_MODE_CTL_C_OE_N && car_sync_ff[1] == car_sync_ff[2])
      nxt_carrier = car_sync_ff[2];
  end

  always_ff @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      car_sync_ff <= 3'h0;
      dat_sync_ff <= 3'h0;
      carrier_ff  <= 1'b0;
    end
    else if (CLK_EN)
    begin
      if (!MEM_MODE_CTL_C_OE_N)  // Own mode level on the pin must never pass as carrier
        car_sync_ff <= {3{carrier_ff}};
      else
        car_sync_ff <= {car_sync_ff[1:0], MEM_MODE_CTL_C_I};
      dat_sync_ff <= {dat_sync_ff[1:0], NVM_DATA_I};
      carrier_ff  <= nxt_carrier;
    end
  end

  // Millisecond tick keeps the long timers within 16 bits
  always_comb
  begin
    nxt_tick = 1'b0;
    nxt_pre  = pre_ff + 18'h1;
    if (pre_ff == 18'(MS_CYCLES - 1))
    begin
      nxt_pre  = 18'h0;
      nxt_tick = 1'b1;
    end
  end

  always_comb
  begin
    nxt_st     = st_ff;
    nxt_blk    = blk_ff;
    nxt_chr    = chr_ff;
    nxt_pls    = pls_ff;
    nxt_sel    = sel_ff;
    nxt_start  = 1'b0;
    nxt_text   = 1'b0;
    nxt_clear  = 1'b0;
    nxt_cvalid = 1'b0;
    nxt_ccode  = CHAR_CODE;
    nxt_ivalid = 1'b0;
    nxt_idig   = ID_DIGIT;
    case (st_ff)
      vad_pkg::ST_IDLE:
        if (is_square && DISP_VIDEOTEX)
        begin
          nxt_st    = vad_pkg::ST_LOOPED;
          nxt_text  = 1'b1;
          nxt_clear = 1'b1;
        end
      vad_pkg::ST_LOOPED:
        if (carrier_ff)
          nxt_st = vad_pkg::ST_ONLINE;
        else if (is_dig)
        begin
          nxt_blk   = dig_blk;
          nxt_chr   = 5'h0;
          nxt_sel   = KEY_CODE;
          nxt_start = 1'b1;
          nxt_st    = vad_pkg::ST_FETCH;
        end
        else if (tmr_ff >= `VAD_LOOP_TIMEOUT_MS)
          nxt_st = vad_pkg::ST_IDLE;
      vad_pkg::ST_FETCH:
        if (done)
        begin
          nxt_chr    = chr_ff + 5'h1;
          nxt_cvalid = 1'b1;
          nxt_st     = vad_pkg::ST_NEXT;
          if (nib <= `VAD_CODE_DIGIT_MAX)
          begin
            nxt_ccode = `VAD_DISP_ZERO + {3'h0, nib};
            nxt_pls   = (nib == 4'h0) ? 4'hA : nib;
            nxt_st    = vad_pkg::ST_BREAK;
          end
          else if (nib == `VAD_CODE_PAUSE)
          begin
            nxt_ccode = `VAD_DISP_STAR;
            nxt_st    = vad_pkg::ST_PAUSE;
          end
          else if (nib == `VAD_CODE_FILL)
            nxt_ccode = `VAD_DISP_SPACE;
          else
            nxt_cvalid = 1'b0;
        end
      vad_pkg::ST_BREAK:
        if (tmr_ff >= `VAD_BREAK_MS)
          nxt_st = vad_pkg::ST_MAKE;
      vad_pkg::ST_MAKE:
        if (tmr_ff >= `VAD_MAKE_MS)
        begin
          nxt_pls = pls_ff - 4'h1;
          nxt_st  = (pls_ff == 4'h1) ? vad_pkg::ST_GAP : vad_pkg::ST_BREAK;
        end
      vad_pkg::ST_GAP:
        if (tmr_ff >= `VAD_INTERDIGIT_MS)
          nxt_st = vad_pkg::ST_NEXT;
      vad_pkg::ST_PAUSE:
        if ((KEY_VALID && KEY_CODE == sel_ff) || tmr_ff >= `VAD_PAUSE_TIMEOUT_MS)
          nxt_st = vad_pkg::ST_NEXT;
      vad_pkg::ST_NEXT:
        if (chr_ff >= `VAD_BLK_CHARS)
          nxt_st = vad_pkg::ST_WAITCAR;
        else
        begin
          nxt_start = 1'b1;
          nxt_st    = vad_pkg::ST_FETCH;
        end
      vad_pkg::ST_WAITCAR:
        if (carrier_ff)
          nxt_st = vad_pkg::ST_ONLINE;
        else if (is_square)
        begin
          nxt_st    = vad_pkg::ST_LOOPED;
          nxt_text  = 1'b1;
          nxt_clear = 1'b1;
        end
        else if (tmr_ff >= `VAD_CARRIER_TIMEOUT_MS)
          nxt_st = vad_pkg::ST_IDLE;
      vad_pkg::ST_ONLINE:
        // Digit keys fall through to the normal keypad path here
        if (ID_REQ)
        begin
          nxt_blk   = `VAD_BLK_IDENTITY;
          nxt_chr   = 5'h0;
          nxt_start = 1'b1;
          nxt_st    = vad_pkg::ST_IDSEND;
        end
      vad_pkg::ST_IDSEND:
        if (done)
        begin
          nxt_chr    = chr_ff + 5'h1;
          nxt_ivalid = (nib <= `VAD_CODE_DIGIT_MAX);
          nxt_idig   = nib;
          if (chr_ff == `VAD_BLK_CHARS - 5'h1)
            nxt_st = vad_pkg::ST_ONLINE;
          else
            nxt_start = 1'b1;
        end
      default:
        nxt_st = vad_pkg::ST_IDLE;
    endcase
    // Releases override the state, text mode, clear and memory start; the store is left as it stands
    if (st_ff != vad_pkg::ST_IDLE)
    begin
      if (is_release || (vtx_ff && !DISP_VIDEOTEX))
      begin
        nxt_st    = vad_pkg::ST_IDLE;
        nxt_clear = 1'b0;
        nxt_text  = 1'b0;
        nxt_start = 1'b0;
      end
      else if ((st_ff == vad_pkg::ST_ONLINE || st_ff == vad_pkg::ST_IDSEND) && !carrier_ff)
      begin
        nxt_st    = vad_pkg::ST_IDLE;
        nxt_start = 1'b0;
      end
    end
  end

  // Timer restarts on every state change
  always_comb
  begin
    nxt_tmr = tmr_ff;
    if (nxt_st != st_ff)
      nxt_tmr = 16'h0;
    else if (tick_ff && tmr_ff != 16'hFFFF)
      nxt_tmr = tmr_ff + 16'h1;
  end

  always_ff @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      st_ff         <= vad_pkg::ST_IDLE;
      pre_ff        <= 18'h0;
      tick_ff       <= 1'b0;
      tmr_ff        <= 16'h0;
      blk_ff        <= 3'h0;
      chr_ff        <= 5'h0;
      pls_ff        <= 4'h0;
      sel_ff        <= 7'h0;
      vtx_ff        <= 1'b0;
      start_ff      <= 1'b0;
      LINE_RELAY    <= 1'b0;
      MASK_RELAY    <= 1'b0;
      DIAL_RELAY    <= 1'b0;
      SET_TEXT_MODE <= 1'b0;
      CLEAR_STORE   <= 1'b0;
      CHAR_VALID    <= 1'b0;
      CHAR_CODE     <= 7'h0;
      ID_VALID      <= 1'b0;
      ID_DIGIT      <= 4'h0;
    end
    else if (CLK_EN)
    begin
      st_ff         <= nxt_st;
      pre_ff        <= nxt_pre;
      tick_ff       <= nxt_tick;
      tmr_ff        <= nxt_tmr;
      blk_ff        <= nxt_blk;
      chr_ff        <= nxt_chr;
      pls_ff        <= nxt_pls;
      sel_ff        <= nxt_sel;
      vtx_ff        <= DISP_VIDEOTEX;
      start_ff      <= nxt_start;
      LINE_RELAY    <= (nxt_st != vad_pkg::ST_IDLE);
      MASK_RELAY    <= (nxt_st inside {vad_pkg::ST_FETCH, vad_pkg::ST_BREAK, vad_pkg::ST_MAKE,
                                       vad_pkg::ST_GAP, vad_pkg::ST_NEXT, vad_pkg::ST_PAUSE});
      DIAL_RELAY    <= (nxt_st == vad_pkg::ST_BREAK);
      SET_TEXT_MODE <= nxt_text;
      CLEAR_STORE   <= nxt_clear;
      CHAR_VALID    <= nxt_cvalid;
      CHAR_CODE     <= nxt_ccode;
      ID_VALID      <= nxt_ivalid;
      ID_DIGIT      <= nxt_idig;
    end
  end
endmodule : vad_dialer

// ===== sim/vad_nvm_model.sv
// Serial store and carrier source on the far side of the memory pins
`timescale 1ns/1ps
`include "vad_map.svh"
module vad_nvm_model (
  input  wire logic clk,
  input  wire logic nvm_clk,
  input  wire logic mode_a,
  input  wire logic mode_b,
  input  wire logic c_o,
  input  wire logic c_oe_n,
  input  wire logic data_o,
  input  wire logic data_oe_n,
  input  wire logic carrier,
  output logic      c_i,
  output logic      data_i
);
  logic [7:0] mem [0:127];
  logic [7:0] addr_sr;
  logic [2:0] bit_idx;
  logic [2:0] mode;
  logic       nclk_q;
  logic       rel;
  assign mode = {c_oe_n ? 1'b0 : c_o, mode_b, mode_a};
  // Released pin senses carrier
  assign c_i = c_oe_n ? carrier : c_o;
  // Floating data line toggles so no stale bit survives
  assign data_i = !data_oe_n ? data_o :
                  (mode == `VAD_NVM_MODE_SHIFT) ? mem[addr_sr[6:0]][3'h7 - bit_idx] : rel;
  initial
  begin
    nclk_q = 1'b0;
    rel = 1'b0;
    addr_sr = 8'h00;
    bit_idx = 3'h7;
    foreach (mem[i]) mem[i] = 8'hFF;
    // Identity in block index 0, numbers in 1, 2, 5, 6
    for (int i = 0; i < 10; i++) mem[i] = 8'h30 + 8'((i * 3 + 1) % 10);
    mem[16] = 8'h32;
    mem[17] = 8'h3B;
    mem[18] = 8'h31;
    mem[32] = 8'h31;
    mem[80] = 8'h3B;
    mem[81] = 8'h33;
    mem[96] = 8'h30;
  end
  // Address taken on the falling edge, away from the data change
  always @(posedge clk)
  begin
    nclk_q <= nvm_clk;
    rel <= ~rel;
    if (nclk_q && !nvm_clk && mode == `VAD_NVM_MODE_ADDR)
      addr_sr <= {addr_sr[6:0], data_o};
    if (mode != `VAD_NVM_MODE_SHIFT)
      bit_idx <= 3'h7;  // First fall in shift mode presents the MSB
    else if (nclk_q && !nvm_clk)
      bit_idx <= bit_idx + 3'h1;
  end
endmodule : vad_nvm_model

// ===== sim/vad_dialer_asserts.sv
// Port checks for the autodialer sequencer
`timescale 1ns/1ps
`include "vad_map.svh"
module vad_dialer_asserts #(
  parameter int MS_CYCLES = 200000,
  parameter int NVM_HALF  = 7142
) (
  input wire logic       CLOCK,
  input wire logic       RSTN,
  input wire logic       CLK_EN,
  input wire logic       KEY_VALID,
  input wire logic [6:0] KEY_CODE,
  input wire logic       DISP_VIDEOTEX,
  input wire logic       LINE_RELAY,
  input wire logic       MASK_RELAY,
  input wire logic       DIAL_RELAY,
  input wire logic       SET_TEXT_MODE,
  input wire logic       CLEAR_STORE,
  input wire logic       CARRIER_UP,
  input wire logic       NVM_CLK,
  input wire logic       MEM_MODE_CTL_C_OE_N
);
  localparam int BRK_LO = (int'(`VAD_BREAK_MS) - 1) * MS_CYCLES;
  localparam int BRK_HI = (int'(`VAD_BREAK_MS) + 1) * MS_CYCLES;
  logic [31:0] brk_ff;
  logic [31:0] nxt_brk;
  logic        sq;
  logic        rel_key;
  assign sq = CLK_EN && KEY_VALID && (KEY_CODE == `VAD_KEY_SQUARE || KEY_CODE == `VAD_ASC_SQUARE);
  assign rel_key = CLK_EN && KEY_VALID && (KEY_CODE == `VAD_KEY_HOLD || KEY_CODE == `VAD_KEY_PICTEXT);
  always_comb nxt_brk = DIAL_RELAY ? brk_ff + 32'h1 : 32'h0;
  always_ff @(posedge CLOCK or negedge RSTN)
    if (!RSTN)
      brk_ff <= 32'h0;
    else
      brk_ff <= nxt_brk;
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RSTN);
  chk_square_loop: assert property (sq && !LINE_RELAY && DISP_VIDEOTEX |=> LINE_RELAY && SET_TEXT_MODE && CLEAR_STORE)
    else $error("square key did not loop the line");
  chk_square_refused: assert property (sq && !LINE_RELAY && !DISP_VIDEOTEX |=> !LINE_RELAY)
    else $error("line looped outside videotex mode");
  chk_key_release: assert property (rel_key && LINE_RELAY |=> !LINE_RELAY && !MASK_RELAY && !DIAL_RELAY)
    else $error("release key left a relay on");
  chk_mode_release: assert property ($fell(DISP_VIDEOTEX) && LINE_RELAY |-> ##[1:2] !LINE_RELAY)
    else $error("mode change did not release the line");
  chk_store_kept: assert property ($fell(LINE_RELAY) |-> !CLEAR_STORE)
    else $error("store cleared on release");
  chk_carrier_loss: assert property ($fell(CARRIER_UP) && LINE_RELAY |=> !LINE_RELAY)
    else $error("carrier loss did not release the line");
  chk_break_len: assert property ($fell(DIAL_RELAY) |-> brk_ff >= BRK_LO && brk_ff <= BRK_HI)
    else $error("dial break length out of range");
  chk_dial_inside: assert property (DIAL_RELAY |-> MASK_RELAY && LINE_RELAY)
    else $error("dial pulse outside a dialing sequence");
  chk_clk_released: assert property (MEM_MODE_CTL_C_OE_N |-> !NVM_CLK)
    else $error("memory clock runs while mode pin released");
  cover property ($fell(DIAL_RELAY));
  cover property ($fell(CARRIER_UP) && LINE_RELAY);
  cover property (rel_key && LINE_RELAY);
endmodule : vad_dialer_asserts
bind vad_dialer vad_dialer_asserts #(.MS_CYCLES(MS_CYCLES), .NVM_HALF(NVM_HALF)) vad_dialer_asserts_i (.*);

// ===== sim/vad_dialer_test.sv
// Self-checking bench for the autodialer sequencer
`timescale 1ns/1ps
`include "vad_map.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_count++; $display("MISMATCH t=%0t got %h exp %h", $time, a, b); end end
`define WAITU(c, lim) begin n = 0; while (!(c)) begin @(posedge CLOCK); #1; n++; if (n > (lim)) begin err_count++; stop_test(); end end end
module vad_dialer_test;
  localparam int MS = 1;
  logic       CLOCK, RSTN, CLK_EN, KEY_VALID, DISP_VIDEOTEX, ID_REQ, carrier, dial_q;
  logic [6:0] KEY_CODE, CHAR_CODE;
  logic       LINE_RELAY, MASK_RELAY, DIAL_RELAY, SET_TEXT_MODE, CLEAR_STORE, CHAR_VALID, ID_VALID;
  logic       CARRIER_UP, NVM_CLK, MEM_MODE_CTL_A, MEM_MODE_CTL_B, MEM_MODE_CTL_C_O, MEM_MODE_CTL_C_OE_N;
  logic       MEM_MODE_CTL_C_I, NVM_DATA_O, NVM_DATA_OE_N, NVM_DATA_I;
  logic [3:0] ID_DIGIT;
  logic [6:0] chars[$];
  logic [3:0] ids[$];
  int         err_count = 0, n_tests = 0, n, pulses;
  vad_dialer #(.MS_CYCLES(MS), .NVM_HALF(8)) vad_dialer_i (.*);
  vad_nvm_model vad_nvm_model_i (.clk(CLOCK), .nvm_clk(NVM_CLK), .mode_a(MEM_MODE_CTL_A), .mode_b(MEM_MODE_CTL_B),
    .c_o(MEM_MODE_CTL_C_O), .c_oe_n(MEM_MODE_CTL_C_OE_N), .data_o(NVM_DATA_O), .data_oe_n(NVM_DATA_OE_N),
    .carrier(carrier), .c_i(MEM_MODE_CTL_C_I), .data_i(NVM_DATA_I));
  initial
  begin
    CLOCK = 1'b0;
    forever #2.5 CLOCK = ~CLOCK;
  end
  always @(posedge CLOCK)
  begin
    if (CHAR_VALID === 1'b1) chars.push_back(CHAR_CODE);
    if (ID_VALID === 1'b1) ids.push_back(ID_DIGIT);
    if (DIAL_RELAY === 1'b1 && dial_q !== 1'b1) pulses++;
    dial_q = DIAL_RELAY;
  end
  task stop_test;
    $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : stop_test
  task key(input logic [6:0] c);
    @(posedge CLOCK);
    KEY_VALID <= 1'b1;
    KEY_CODE <= c;
    @(posedge CLOCK);
    KEY_VALID <= 1'b0;
    #1;
  endtask : key
  task dial(input logic [6:0] sq, input logic [6:0] c);
    chars.delete();
    pulses = 0;
    key(sq);
    key(c);
    `CHK(MASK_RELAY, 1'b1)
  endtask : dial
  task video(input logic v, input logic cr);
    @(posedge CLOCK);
    DISP_VIDEOTEX <= v;
    carrier <= cr;
  endtask : video
  task t_keys;
    video(1'b0, 1'b0);
    key(`VAD_KEY_SQUARE);
    `CHK(LINE_RELAY, 1'b0)
    video(1'b1, 1'b0);
    key(`VAD_KEY_DIG1);
    `CHK(MASK_RELAY, 1'b0)
    @(posedge CLOCK);
    CLK_EN <= 1'b0;
    key(`VAD_KEY_SQUARE);
    `CHK(LINE_RELAY, 1'b0)
    @(posedge CLOCK);
    CLK_EN <= 1'b1;
    key(`VAD_KEY_SQUARE);
    `CHK({LINE_RELAY, SET_TEXT_MODE, CLEAR_STORE}, 3'h7)
    key(`VAD_KEY_HOLD);
    `CHK({LINE_RELAY, CLEAR_STORE}, 2'h0)
    key(`VAD_KEY_SQUARE);
    key(`VAD_KEY_PICTEXT);
    `CHK(LINE_RELAY, 1'b0)
    key(`VAD_KEY_SQUARE);
    video(1'b0, 1'b0);
    repeat (3) @(posedge CLOCK);
    #1 `CHK({LINE_RELAY, CLEAR_STORE}, 2'h0)
    video(1'b1, 1'b0);
    $display("test keys done");
  endtask : t_keys
  task t_dial_a;
    dial(`VAD_KEY_SQUARE, `VAD_KEY_DIG1);
    `WAITU(chars.size() == 2, 8000)
    `CHK({chars[0], chars[1]}, {7'h32, `VAD_DISP_STAR})
    `CHK(pulses, 2)
    key(`VAD_KEY_DIG1);
    `WAITU(chars.size() == 3, 1000)
    `CHK(chars[2], 7'h31)
    `WAITU(!MASK_RELAY, 8000)
    `CHK(pulses, 3)
    `CHK(chars.size(), 16)
    `CHK(chars[15], `VAD_DISP_SPACE)
    video(1'b1, 1'b1);
    `WAITU(CARRIER_UP, 50)
    key(`VAD_KEY_DIG2);
    `CHK({LINE_RELAY, MASK_RELAY}, 2'h2)
    @(posedge CLOCK);
    ID_REQ <= 1'b1;
    @(posedge CLOCK);
    ID_REQ <= 1'b0;
    `WAITU(ids.size() == 10, 8000)
    for (int i = 0; i < 10; i++) `CHK(ids[i], 4'((i * 3 + 1) % 10))
    video(1'b1, 1'b0);
    `WAITU(!CARRIER_UP, 3000)
    @(posedge CLOCK);
    #1 `CHK(LINE_RELAY, 1'b0)
    $display("test dial a done");
  endtask : t_dial_a
  task t_pause;
    dial(`VAD_KEY_SQUARE, `VAD_KEY_DIG3);
    `WAITU(chars.size() == 1, 1000)
    `CHK(chars[0], `VAD_DISP_STAR)
    `WAITU(chars.size() == 2, 5000)
    `CHK(n >= 4000 * MS && n < 4000 * MS + 400, 1'b1)
    `WAITU(!MASK_RELAY, 8000)
    `CHK(pulses, 3)
    key(`VAD_KEY_SQUARE);
    `CHK({LINE_RELAY, SET_TEXT_MODE, CLEAR_STORE}, 3'h7)
    `WAITU(!LINE_RELAY, 31000 * MS)
    `CHK(n >= 29998 * MS && n <= 30002 * MS, 1'b1)
    $display("test pause done");
  endtask : t_pause
  task t_no_carrier;
    dial(`VAD_KEY_SQUARE, `VAD_KEY_DIG2);
    `WAITU(!MASK_RELAY, 8000)
    `CHK({chars[0], pulses[3:0]}, {7'h31, 4'h1})
    `WAITU(!LINE_RELAY, 31000 * MS)
    `CHK(n >= 29998 * MS && n <= 30002 * MS, 1'b1)
    $display("test no carrier done");
  endtask : t_no_carrier
  task t_zero;
    dial(`VAD_ASC_SQUARE, `VAD_ASC_DIG4);
    `WAITU(!MASK_RELAY, 8000)
    `CHK({chars[0], pulses[4:0]}, {7'h30, 5'd10})
    video(1'b1, 1'b1);
    `WAITU(CARRIER_UP, 50)
    video(1'b0, 1'b1);
    repeat (3) @(posedge CLOCK);
    #1 `CHK({LINE_RELAY, CLEAR_STORE}, 2'h0)
    video(1'b1, 1'b0);
    `WAITU(!CARRIER_UP, 50)
    $display("test zero done");
  endtask : t_zero
  task t_manual;
    key(`VAD_KEY_SQUARE);
    video(1'b1, 1'b1);
    `WAITU(CARRIER_UP, 50)
    @(posedge CLOCK);
    #1 `CHK({LINE_RELAY, MASK_RELAY}, 2'h2)
    key(`VAD_KEY_HOLD);
    `CHK(LINE_RELAY, 1'b0)
    video(1'b1, 1'b0);
    `WAITU(!CARRIER_UP, 50)
    $display("test manual done");
  endtask : t_manual
  initial
  begin
    RSTN = 1'b0;
    CLK_EN = 1'b1;
    KEY_VALID = 1'b0;
    KEY_CODE = 7'h00;
    DISP_VIDEOTEX = 1'b1;
    ID_REQ = 1'b0;
    carrier = 1'b0;
    repeat (12) @(posedge CLOCK);
    `CHK({LINE_RELAY, MASK_RELAY, DIAL_RELAY, CARRIER_UP, NVM_CLK}, 5'h00)
    `CHK({MEM_MODE_CTL_C_OE_N, NVM_DATA_OE_N}, 2'h3)
    RSTN <= 1'b1;
    t_keys();
    t_dial_a();
    t_pause();
    t_no_carrier();
    t_zero();
    t_manual();
    stop_test();
  end
endmodule : vad_dialer_test
